// ==== hdl/cra_defs.vh ====
// Constants of the first custom reference profile register bank.
// Assumes an Avalon-MM byte address whose word index is address[9:2].
// Operation
// - Frequency units: low byte, six high bits.
// - Frequency units count in 8 kHz steps.
// - Single-cycle lower limit is own byte.
// - Single-cycle upper limit is separate byte.
// - Coarse lower limit: two bytes, low first.
// - Coarse upper limit: two bytes, low first.
// - Profile applies only where mode field equals one.
// - Window cycles equal programmed setting plus one.
`ifndef CRA_DEFS_VH
`define CRA_DEFS_VH

// Register indexes; the byte address is four times the index.
`define CRA_IDX_MODE_0          8'h65
`define CRA_IDX_MODE_1          8'h66
`define CRA_IDX_FREQ_LOW        8'h67
`define CRA_IDX_FREQ_HIGH       8'h68
`define CRA_IDX_CYCLE_LOWER     8'h69
`define CRA_IDX_CYCLE_UPPER     8'h6a
`define CRA_IDX_COARSE_LOWER_LO 8'h6b
`define CRA_IDX_COARSE_LOWER_HI 8'h6c
`define CRA_IDX_COARSE_UPPER_LO 8'h6d
`define CRA_IDX_COARSE_UPPER_HI 8'h6e
`define CRA_IDX_WINDOW_CYCLES   8'h6f
`define CRA_IDX_FAIL_STICKY     8'h80
`define CRA_IDX_FAIL_LIVE       8'h81

// Reset value shared by every writable byte.
`define CRA_RST_BYTE            8'h00

// Field layout.
`define CRA_FREQ_HIGH_BITS      6
`define CRA_MODE_1_BITS         2
`define CRA_NUM_REF             5
`define CRA_MODE_WIDTH          2
`define CRA_MODE_AUTO           2'h0
`define CRA_MODE_PROFILE_A      2'h1
`define CRA_MODE_PROFILE_B      2'h2

// One frequency unit in kHz.
`define CRA_FREQ_UNIT_KHZ       8
`define CRA_FREQ_UNIT_SHIFT     3

`endif

// ==== hdl/cra_regs.v ====
// Register bank and limit check for the first custom reference profile.
// Assumes an Avalon-MM master on core_clk and monitor counts synchronous to core_clk.
`timescale 1ns/10ps
`include "cra_defs.vh"

module cra_regs (
	// Clock and reset.
	input  wire        core_clk,
	input  wire        resetn,
	// Avalon-MM slave.
	input  wire [9:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [3:0]  byteenable,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	// Measured counts, one lane per reference.
	input  wire [39:0] ref_cycle_count,
	input  wire [79:0] ref_coarse_count,
	input  wire [4:0]  ref_meas_valid,
	// Settings toward the monitor.
	output wire [13:0] profile_a_freq_units,
	output reg  [16:0] profile_a_expected_khz,
	output wire [7:0]  profile_a_cycle_lower_limit,
	output wire [7:0]  profile_a_cycle_upper_limit,
	output wire [15:0] profile_a_coarse_lower,
	output wire [15:0] profile_a_coarse_upper,
	output reg  [8:0]  profile_a_window_cycles,
	output reg  [4:0]  profile_a_ref_select,
	output reg  [4:0]  profile_a_ref_fail
);

	// Stored bytes.
	reg  [7:0]  mode_0_ff;
	reg  [1:0]  mode_1_ff;
	reg  [7:0]  freq_low_ff;
	reg  [5:0]  freq_high_ff;
	reg  [7:0]  cycle_lower_ff;
	reg  [7:0]  cycle_upper_ff;
	reg  [7:0]  coarse_lower_lo_ff;
	reg  [7:0]  coarse_lower_hi_ff;
	reg  [7:0]  coarse_upper_lo_ff;
	reg  [7:0]  coarse_upper_hi_ff;
	reg  [7:0]  window_cycles_ff;
	reg  [4:0]  fail_sticky_ff;

	// Bus and decode.
	wire        req;
	wire        accept;
	wire        wr_en;
	wire [7:0]  idx;
	wire [7:0]  wbyte;
	wire [9:0]  mode_all;
	wire [4:0]  fail_event;
	reg  [31:0] nxt_readdata;
	reg  [4:0]  nxt_fail_sticky;

	assign req    = read | write;
	assign accept = req & ~waitrequest;
	assign idx    = address[9:2];
	assign wbyte  = writedata[7:0];
	assign wr_en  = write & accept & byteenable[0] & (address[1:0] == 2'h0);

	assign mode_all = {mode_1_ff, mode_0_ff};

	assign profile_a_freq_units        = {freq_high_ff, freq_low_ff};
	assign profile_a_cycle_lower_limit = cycle_lower_ff;
	assign profile_a_cycle_upper_limit = cycle_upper_ff;
	assign profile_a_coarse_lower      = {coarse_lower_hi_ff, coarse_lower_lo_ff};
	assign profile_a_coarse_upper      = {coarse_upper_hi_ff, coarse_upper_lo_ff};

	// One wait state, then the answer stands for the accepting edge.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			waitrequest <= ~(req & waitrequest);
			if (req & waitrequest) begin
				readdata <= nxt_readdata;
			end
		end
	end

	// Register writes; reserved high bits are never stored.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_0_ff          <= `CRA_RST_BYTE;
			mode_1_ff          <= 2'h0;
			freq_low_ff        <= `CRA_RST_BYTE;
			freq_high_ff       <= 6'h00;
			cycle_lower_ff     <= `CRA_RST_BYTE;
			cycle_upper_ff     <= `CRA_RST_BYTE;
			coarse_lower_lo_ff <= `CRA_RST_BYTE;
			coarse_lower_hi_ff <= `CRA_RST_BYTE;
			coarse_upper_lo_ff <= `CRA_RST_BYTE;
			coarse_upper_hi_ff <= `CRA_RST_BYTE;
			window_cycles_ff   <= `CRA_RST_BYTE;
		end else if (wr_en) begin
			case (idx)
				`CRA_IDX_MODE_0:          mode_0_ff <= wbyte;
				`CRA_IDX_MODE_1:          mode_1_ff <= wbyte[1:0];
				`CRA_IDX_FREQ_LOW:        freq_low_ff <= wbyte;
				`CRA_IDX_FREQ_HIGH:       freq_high_ff <= wbyte[5:0];
				`CRA_IDX_CYCLE_LOWER:     cycle_lower_ff <= wbyte;
				`CRA_IDX_CYCLE_UPPER:     cycle_upper_ff <= wbyte;
				`CRA_IDX_COARSE_LOWER_LO: coarse_lower_lo_ff <= wbyte;
				`CRA_IDX_COARSE_LOWER_HI: coarse_lower_hi_ff <= wbyte;
				`CRA_IDX_COARSE_UPPER_LO: coarse_upper_lo_ff <= wbyte;
				`CRA_IDX_COARSE_UPPER_HI: coarse_upper_hi_ff <= wbyte;
				`CRA_IDX_WINDOW_CYCLES:   window_cycles_ff <= wbyte;
				default: begin
				end
			endcase
		end
	end

	// Read multiplexer; unmapped and misaligned addresses read zero.
	always @* begin
		nxt_readdata = 32'h0000_0000;
		if (address[1:0] == 2'h0) begin
			case (idx)
				`CRA_IDX_MODE_0:          nxt_readdata[7:0] = mode_0_ff;
				`CRA_IDX_MODE_1:          nxt_readdata[1:0] = mode_1_ff;
				`CRA_IDX_FREQ_LOW:        nxt_readdata[7:0] = freq_low_ff;
				`CRA_IDX_FREQ_HIGH:       nxt_readdata[5:0] = freq_high_ff;
				`CRA_IDX_CYCLE_LOWER:     nxt_readdata[7:0] = cycle_lower_ff;
				`CRA_IDX_CYCLE_UPPER:     nxt_readdata[7:0] = cycle_upper_ff;
				`CRA_IDX_COARSE_LOWER_LO: nxt_readdata[7:0] = coarse_lower_lo_ff;
				`CRA_IDX_COARSE_LOWER_HI: nxt_readdata[7:0] = coarse_lower_hi_ff;
				`CRA_IDX_COARSE_UPPER_LO: nxt_readdata[7:0] = coarse_upper_lo_ff;
				`CRA_IDX_COARSE_UPPER_HI: nxt_readdata[7:0] = coarse_upper_hi_ff;
				`CRA_IDX_WINDOW_CYCLES:   nxt_readdata[7:0] = window_cycles_ff;
				`CRA_IDX_FAIL_STICKY:     nxt_readdata[4:0] = fail_sticky_ff;
				`CRA_IDX_FAIL_LIVE:       nxt_readdata[4:0] = profile_a_ref_fail;
				default:                  nxt_readdata = 32'h0000_0000;
			endcase
		end
	end

	// Derived settings.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			profile_a_expected_khz  <= 17'h00000;
			profile_a_window_cycles <= 9'h001;
		end else begin
			profile_a_expected_khz  <= {profile_a_freq_units, 3'h0};
			profile_a_window_cycles <= {1'b0, window_cycles_ff} + 9'h001;
		end
	end

	// Per-reference profile selection and limit check.
	genvar g;
	generate
		for (g = 0; g < `CRA_NUM_REF; g = g + 1) begin : g_ref
			wire       sel;
			wire [7:0] cyc;
			wire [15:0] crs;
			wire       bad;

			assign sel = (mode_all[2*g+1:2*g] == `CRA_MODE_PROFILE_A);
			assign cyc = ref_cycle_count[8*g+7:8*g];
			assign crs = ref_coarse_count[16*g+15:16*g];
			assign bad = (cyc < cycle_lower_ff) | (cyc > cycle_upper_ff) |
				(crs < profile_a_coarse_lower) | (crs > profile_a_coarse_upper);
			assign fail_event[g] = sel & ref_meas_valid[g] & bad;

			always @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					profile_a_ref_select[g] <= 1'b0;
					profile_a_ref_fail[g]   <= 1'b0;
				end else begin
					profile_a_ref_select[g] <= sel;
					if (!sel) begin
						profile_a_ref_fail[g] <= 1'b0;
					end else if (ref_meas_valid[g]) begin
						profile_a_ref_fail[g] <= bad;
					end
				end
			end
		end
	endgenerate

	// Sticky fail flags: write one to clear, a new failure wins.
	always @* begin
		nxt_fail_sticky = fail_sticky_ff;
		if (wr_en && (idx == `CRA_IDX_FAIL_STICKY)) begin
			nxt_fail_sticky = fail_sticky_ff & ~wbyte[4:0];
		end
		nxt_fail_sticky = nxt_fail_sticky | fail_event;
	end

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fail_sticky_ff <= 5'h00;
		end else begin
			fail_sticky_ff <= nxt_fail_sticky;
		end
	end

endmodule // cra_regs

// ==== verif/cra_regs_assertions.sv ====
// Assertions on the profile A register bank ports.
// Assumes it is bound to every cra_regs instance.
`timescale 1ns/10ps
module cra_regs_assertions (
	input wire        core_clk,
	input wire        resetn,
	input wire [9:0]  address,
	input wire        write,
	input wire        waitrequest,
	input wire [3:0]  byteenable,
	input wire [31:0] writedata,
	input wire [39:0] ref_cycle_count,
	input wire [79:0] ref_coarse_count,
	input wire [4:0]  ref_meas_valid,
	input wire [13:0] profile_a_freq_units,
	input wire [16:0] profile_a_expected_khz,
	input wire [7:0]  profile_a_cycle_lower_limit,
	input wire [7:0]  profile_a_cycle_upper_limit,
	input wire [15:0] profile_a_coarse_lower,
	input wire [15:0] profile_a_coarse_upper,
	input wire [8:0]  profile_a_window_cycles,
	input wire [4:0]  profile_a_ref_select,
	input wire [4:0]  profile_a_ref_fail
);
	// Accepted byte write, and lane 0 outside its limits.
	wire wr = write && !waitrequest && byteenable[0];
	wire oor = ref_cycle_count[7:0] < profile_a_cycle_lower_limit ||
		ref_cycle_count[7:0] > profile_a_cycle_upper_limit ||
		ref_coarse_count[15:0] < profile_a_coarse_lower ||
		ref_coarse_count[15:0] > profile_a_coarse_upper;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	chk_freq_high: assert property (wr && address == 10'h1a0 |=>
		profile_a_freq_units[13:8] == $past(writedata[5:0])) else $error("freq high");
	chk_khz_scale: assert property (1 |=>
		profile_a_expected_khz == {$past(profile_a_freq_units), 3'h0}) else $error("khz");
	chk_cycle_lower: assert property (wr && address == 10'h1a4 |=>
		profile_a_cycle_lower_limit == $past(writedata[7:0])) else $error("cycle lower");
	chk_cycle_upper: assert property (wr && address == 10'h1a8 |=>
		profile_a_cycle_upper_limit == $past(writedata[7:0])) else $error("cycle upper");
	chk_coarse_lower: assert property (wr && address == 10'h1b0 |=>
		profile_a_coarse_lower[15:8] == $past(writedata[7:0])) else $error("coarse lower");
	chk_coarse_upper: assert property (wr && address == 10'h1b4 |=>
		profile_a_coarse_upper[7:0] == $past(writedata[7:0])) else $error("coarse upper");
	chk_fail_select: assert property ((profile_a_ref_fail & ~profile_a_ref_select) == 5'h0)
		else $error("fail on unselected");
	chk_window_plus: assert property (wr && address == 10'h1bc |-> ##2
		profile_a_window_cycles == $past(writedata[7:0], 2) + 9'h1) else $error("window");
	chk_limit_fail: assert property (ref_meas_valid[0] && profile_a_ref_select[0] |=>
		profile_a_ref_fail[0] == $past(oor)) else $error("limit fail");
endmodule // cra_regs_assertions

bind cra_regs cra_regs_assertions chk_u (.core_clk, .resetn, .address, .write, .waitrequest,
	.byteenable, .writedata, .ref_cycle_count, .ref_coarse_count, .ref_meas_valid,
	.profile_a_freq_units, .profile_a_expected_khz, .profile_a_cycle_lower_limit,
	.profile_a_cycle_upper_limit, .profile_a_coarse_lower, .profile_a_coarse_upper,
	.profile_a_window_cycles, .profile_a_ref_select, .profile_a_ref_fail);

// ==== verif/custom_ref_a_monitor_config_bench.sv ====
// Self-checking bench of the profile A register bank.
// Assumes cra_regs with one wait state per Avalon request.
`timescale 1ns/10ps
module custom_ref_a_monitor_config_bench;
	logic        core_clk = 0, resetn = 0, read = 0, write = 0, waitrequest;
	logic [9:0]  address = 0;
	logic [3:0]  byteenable = 4'h1;
	logic [31:0] writedata = 0, readdata, exp_q[$];
	logic [39:0] ref_cycle_count = 0;
	logic [79:0] ref_coarse_count = 0;
	logic [4:0]  ref_meas_valid = 0, profile_a_ref_select, profile_a_ref_fail;
	logic [13:0] profile_a_freq_units;
	logic [16:0] profile_a_expected_khz;
	logic [7:0]  profile_a_cycle_lower_limit, profile_a_cycle_upper_limit, v[8];
	logic [15:0] profile_a_coarse_lower, profile_a_coarse_upper;
	logic [8:0]  profile_a_window_cycles;
	logic [7:0]  lim[6] = '{8'h10, 8'h20, 8'h00, 8'h01, 8'h00, 8'h02};
	logic [7:0]  cc[6] = '{8'h10, 8'h0f, 8'h21, 8'h20, 8'h15, 8'h20};
	logic [15:0] cf[6] = '{16'h0100, 16'h0150, 16'h0150, 16'h00ff, 16'h0201, 16'h0200};
	logic        ef[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	integer      fails = 0, checks = 0, seed = 32'h5c5f, cyc = 0, i;
	always #4 core_clk = ~core_clk;
	cra_regs dut_u (.core_clk, .resetn, .address, .read, .write, .byteenable, .writedata,
		.readdata, .waitrequest, .ref_cycle_count, .ref_coarse_count, .ref_meas_valid,
		.profile_a_freq_units, .profile_a_expected_khz, .profile_a_cycle_lower_limit,
		.profile_a_cycle_upper_limit, .profile_a_coarse_lower, .profile_a_coarse_upper,
		.profile_a_window_cycles, .profile_a_ref_select, .profile_a_ref_fail);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One Avalon transfer; a read leaves its expected data in the queue.
	task automatic bus(input bit w, input integer idx, input logic [7:0] d, input logic [7:0] e);
		if (!w) exp_q.push_back({24'h0, e});
		address <= idx[7:0] * 4;
		writedata <= {24'h0, d};
		write <= w;
		read <= !w;
		do @(posedge core_clk); while (waitrequest);
		write <= 0;
		read <= 0;
		@(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		if (read && !waitrequest) check(readdata, exp_q.pop_front());
		if (++cyc > 3000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1;
		@(posedge core_clk);
		for (i = 'h65; i <= 'h6f; i++) bus(0, i, 0, 8'h00);
		bus(0, 'h90, 0, 8'h00);
		for (i = 0; i < 8; i++) begin
			v[i] = $random(seed);
			bus(1, 'h67 + i, v[i], 0);
			bus(0, 'h67 + i, 0, i == 1 ? v[i] & 8'h3f : v[i]);
		end
		bus(1, 'h6f, 8'hff, 0);
		@(negedge core_clk);
		check(profile_a_freq_units, {v[1][5:0], v[0]});
		check(profile_a_expected_khz, {v[1][5:0], v[0], 3'h0});
		check(profile_a_cycle_lower_limit, v[2]);
		check(profile_a_cycle_upper_limit, v[3]);
		check(profile_a_coarse_lower, {v[5], v[4]});
		check(profile_a_coarse_upper, {v[7], v[6]});
		check(profile_a_window_cycles, 9'h100);
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk);
			bus(1, 'h65, (i + 2) % 4, 0);
			@(negedge core_clk);
			check(profile_a_ref_select, {4'h0, (i + 2) % 4 == 1});
		end
		@(posedge core_clk);
		for (i = 0; i < 6; i++) bus(1, 'h69 + i, lim[i], 0);
		for (i = 0; i < 6; i++) begin
			ref_cycle_count <= {$random(seed), cc[i]};
			ref_coarse_count <= {$random(seed), $random(seed), cf[i]};
			ref_meas_valid <= 5'h1f;
			@(posedge core_clk);
			ref_meas_valid <= 5'h00;
			@(negedge core_clk);
			check(profile_a_ref_fail, {4'h0, ef[i]});
			@(posedge core_clk);
		end
		bus(0, 'h80, 0, 8'h01);
		bus(0, 'h81, 0, 8'h00);
		bus(1, 'h80, 8'h1f, 0);
		bus(0, 'h80, 0, 8'h00);
		conclude();
	end
endmodule // custom_ref_a_monitor_config_bench
